// ===== core/jbs_tap.sv
/*
  Boundary scan test logic: TAP controller, 3-bit instruction register,
  one-bit bypass stage and a boundary chain over the processor pins.
  Assumes a power-on reset (resetn) only; processor resets never reach here.
  Pin values come from the system clock domain and are synchronised into the
  test clock domain before capture.
*/
`timescale 1ns/10ps
// Functional notes
// - support bypass, extest and sample/preload
// - power-on reset holds logic until clocked
// - processor resets never touch test logic
// - only bypass, boundary and instruction registers
// - bypass stage is default serial path
// - bypass passes data without inversion
// - one boundary cell per pin, uninverted
// - input cells capture only, never drive
// - boundary chain selected by extest/sample only
// - three-bit instruction selects path and operation
// - tap state machine sequences all actions
// - codes 000 extest, 110 sample, 111 bypass
// - state changes on rising edge by mode
// - five high edges reset, force bypass
// - shift-data advances one stage per edge
module jbs_tap
  import jbs_pkg::*;
#(
  parameter int unsigned N_IN  = 8,
  parameter int unsigned N_OUT = 8
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             test_clock_in,
  input  wire logic             test_mode_select_in,
  input  wire logic             test_serial_in,
  output logic                  test_serial_out,
  output logic                  test_serial_out_oe,
  input  wire logic             cold_reset_n,
  input  wire logic             warm_reset_n,
  input  wire logic             supply_good,
  input  wire logic [N_IN-1:0]  pin_in,
  input  wire logic [N_OUT-1:0] core_out,
  output logic      [N_OUT-1:0] pin_out,
  output logic                  extest_active
);

  localparam int unsigned N_CELLS = N_IN + N_OUT;

  jbs_state_t             state_q;
  jbs_state_t             state_d;
  logic [JBS_IR_WIDTH-1:0] ir_shift_q;
  logic [JBS_IR_WIDTH-1:0] ir_q;
  logic                   bypass_q;
  logic [N_CELLS-1:0]     bsr_q;
  logic [N_OUT-1:0]       upd_q;
  logic [N_CELLS-1:0]     pins_sync;
  logic                   sel_bsr;
  logic                   serial_mux;
  logic                   shifting;
  logic                   sel_ir_shift;
  logic                   proc_reset_seen;

  // processor resets are deliberately not connected to any flop
  assign proc_reset_seen = cold_reset_n & warm_reset_n & supply_good;

  jbs_sync #(
    .WIDTH (N_CELLS)
  ) u_pin_sync (
    .clk    (test_clock_in),
    .resetn (resetn),
    .din    ({core_out, pin_in}),
    .dout   (pins_sync)
  );

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      JBS_ST_RESET:      state_d = test_mode_select_in ? JBS_ST_RESET      : JBS_ST_IDLE;
      JBS_ST_IDLE:       state_d = test_mode_select_in ? JBS_ST_SEL_DR     : JBS_ST_IDLE;
      JBS_ST_SEL_DR:     state_d = test_mode_select_in ? JBS_ST_SEL_IR     : JBS_ST_CAPTURE_DR;
      JBS_ST_CAPTURE_DR: state_d = test_mode_select_in ? JBS_ST_EXIT1_DR   : JBS_ST_SHIFT_DR;
      JBS_ST_SHIFT_DR:   state_d = test_mode_select_in ? JBS_ST_EXIT1_DR   : JBS_ST_SHIFT_DR;
      JBS_ST_EXIT1_DR:   state_d = test_mode_select_in ? JBS_ST_UPDATE_DR  : JBS_ST_PAUSE_DR;
      JBS_ST_PAUSE_DR:   state_d = test_mode_select_in ? JBS_ST_EXIT2_DR   : JBS_ST_PAUSE_DR;
      JBS_ST_EXIT2_DR:   state_d = test_mode_select_in ? JBS_ST_UPDATE_DR  : JBS_ST_SHIFT_DR;
      JBS_ST_UPDATE_DR:  state_d = test_mode_select_in ? JBS_ST_SEL_DR     : JBS_ST_IDLE;
      JBS_ST_SEL_IR:     state_d = test_mode_select_in ? JBS_ST_RESET      : JBS_ST_CAPTURE_IR;
      JBS_ST_CAPTURE_IR: state_d = test_mode_select_in ? JBS_ST_EXIT1_IR   : JBS_ST_SHIFT_IR;
      JBS_ST_SHIFT_IR:   state_d = test_mode_select_in ? JBS_ST_EXIT1_IR   : JBS_ST_SHIFT_IR;
      JBS_ST_EXIT1_IR:   state_d = test_mode_select_in ? JBS_ST_UPDATE_IR  : JBS_ST_PAUSE_IR;
      JBS_ST_PAUSE_IR:   state_d = test_mode_select_in ? JBS_ST_EXIT2_IR   : JBS_ST_PAUSE_IR;
      JBS_ST_EXIT2_IR:   state_d = test_mode_select_in ? JBS_ST_UPDATE_IR  : JBS_ST_SHIFT_IR;
      JBS_ST_UPDATE_IR:  state_d = test_mode_select_in ? JBS_ST_SEL_DR     : JBS_ST_IDLE;
      default:           state_d = JBS_ST_RESET;
    endcase
  end

  // power-on reset parks the controller until the tester clocks it
  always_ff @(posedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
      state_q <= JBS_ST_RESET;
    else
      state_q <= state_d;
  end

  // instruction shift stage
  always_ff @(posedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
      ir_shift_q <= JBS_IR_BYPASS;
    else if (state_q == JBS_ST_CAPTURE_IR)
      ir_shift_q <= {{(JBS_IR_WIDTH-2){1'b0}}, JBS_IR_CAPTURE};
    else if (state_q == JBS_ST_SHIFT_IR)
      ir_shift_q <= {test_serial_in, ir_shift_q[JBS_IR_WIDTH-1:1]};
  end

  // instruction output latch, updated on the falling edge
  always_ff @(negedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
      ir_q <= JBS_IR_BYPASS;
    else if (state_q == JBS_ST_RESET)
      ir_q <= JBS_IR_BYPASS;
    else if (state_q == JBS_ST_UPDATE_IR)
      ir_q <= ir_shift_q;
  end

  assign sel_bsr = (ir_q == JBS_IR_EXTEST) || (ir_q == JBS_IR_SAMPLE);

  // bypass stage
  always_ff @(posedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
      bypass_q <= 1'b0;
    else if (state_q == JBS_ST_CAPTURE_DR)
      bypass_q <= 1'b0;
    else if (state_q == JBS_ST_SHIFT_DR && !sel_bsr)
      bypass_q <= test_serial_in;
  end

  // boundary chain: cell 0 nearest the serial output
  always_ff @(posedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
      bsr_q <= '0;
    else if (sel_bsr && state_q == JBS_ST_CAPTURE_DR)
      bsr_q <= pins_sync;
    else if (sel_bsr && state_q == JBS_ST_SHIFT_DR)
      bsr_q <= {test_serial_in, bsr_q[N_CELLS-1:1]};
  end

  // output cells latch on falling edge of update-data
  always_ff @(negedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
      upd_q <= '0;
    else if (sel_bsr && state_q == JBS_ST_UPDATE_DR)
      upd_q <= bsr_q[N_CELLS-1:N_IN];
  end

  // input cells never feed pin_out; only output cells drive in extest
  always_ff @(negedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
      extest_active <= 1'b0;
    else
      extest_active <= (ir_q == JBS_IR_EXTEST) && (state_q != JBS_ST_RESET);
  end

  assign pin_out = extest_active ? upd_q : core_out;

  assign shifting     = (state_q == JBS_ST_SHIFT_DR) || (state_q == JBS_ST_SHIFT_IR);
  assign sel_ir_shift = (state_q == JBS_ST_SHIFT_IR);
  assign serial_mux   = sel_ir_shift ? ir_shift_q[0] : (sel_bsr ? bsr_q[0] : bypass_q);

  // serial output retimed to the falling edge
  always_ff @(negedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
    begin
      test_serial_out    <= 1'b0;
      test_serial_out_oe <= 1'b0;
    end
    else
    begin
      test_serial_out    <= serial_mux;
      test_serial_out_oe <= shifting;
    end
  end

  logic [2:0] tms_hi_cnt_q;

  always_ff @(posedge test_clock_in or negedge resetn)
  begin
    if (!resetn)
      tms_hi_cnt_q <= 3'h0;
    else if (!test_mode_select_in)
      tms_hi_cnt_q <= 3'h0;
    else if (tms_hi_cnt_q != 3'h7)
      tms_hi_cnt_q <= tms_hi_cnt_q + 3'h1;
  end

  AST_TMS_RESET: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (tms_hi_cnt_q >= 3'(JBS_RESET_EDGES)) |-> state_q == JBS_ST_RESET)
    else $error("five high mode edges did not reach reset");

  AST_RESET_BYPASS: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_RESET) ##1 (state_q == JBS_ST_RESET) |-> ir_q == JBS_IR_BYPASS)
    else $error("reset state did not force bypass");

  AST_BYPASS_PATH: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_DR && !sel_bsr) |=> bypass_q == $past(test_serial_in))
    else $error("bypass stage inverted or lost data");

  AST_BSR_SHIFT: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_DR && sel_bsr) |=> bsr_q[N_CELLS-2:0] == $past(bsr_q[N_CELLS-1:1]))
    else $error("boundary chain did not advance one stage");

  AST_BSR_HOLD: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (!sel_bsr) |=> $stable(bsr_q))
    else $error("boundary chain changed while not selected");

  AST_SHIFT_IR: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_IR && !test_mode_select_in) |=> state_q == JBS_ST_SHIFT_IR)
    else $error("shift state left with mode low");

  AST_OE_SHIFT: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_IDLE) ##1 (state_q == JBS_ST_IDLE) |-> !test_serial_out_oe)
    else $error("serial output driven outside shift");

  AST_SEL_BSR: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_DR && ir_q != JBS_IR_EXTEST && ir_q != JBS_IR_SAMPLE) |-> test_serial_out == bypass_q)
    else $error("serial output not fed by bypass stage");

  AST_TDO_BSR: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_DR && (ir_q == JBS_IR_EXTEST || ir_q == JBS_IR_SAMPLE)) |-> test_serial_out == bsr_q[0])
    else $error("serial output not fed by boundary chain");

  AST_IR_OUT: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_IR) |-> test_serial_out == ir_shift_q[0])
    else $error("serial output not fed by instruction stage");

  AST_OE_ON: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_DR || state_q == JBS_ST_SHIFT_IR) |-> test_serial_out_oe)
    else $error("serial output not driven in shift");

  // instruction path and state transition checks
  AST_IR_CAPTURE: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_CAPTURE_IR) |=> ir_shift_q == JBS_IR_WIDTH'(JBS_IR_CAPTURE))
    else $error("instruction capture value wrong");

  AST_IR_SHIFT: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_IR) |=> ir_shift_q == {$past(test_serial_in), $past(ir_shift_q[JBS_IR_WIDTH-1:1])})
    else $error("instruction stage did not shift");

  AST_IR_LOAD: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_UPDATE_IR) |-> ir_q == ir_shift_q)
    else $error("instruction not loaded in update");

  AST_IR_HOLD: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q != JBS_ST_UPDATE_IR && state_q != JBS_ST_RESET) |-> $stable(ir_q))
    else $error("instruction changed outside update");

  AST_EXTEST_FLAG: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_RESET) |-> !extest_active)
    else $error("extest left active in reset state");

  AST_SEL_IR_RESET: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SEL_IR && test_mode_select_in) |=> state_q == JBS_ST_RESET)
    else $error("select-ir with mode high missed reset");

  AST_SHIFT_DR_STAY: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_SHIFT_DR && !test_mode_select_in) |=> state_q == JBS_ST_SHIFT_DR)
    else $error("shift-data left with mode low");

  // data register checks
  AST_BYPASS_CAPTURE: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_CAPTURE_DR && !sel_bsr) |=> !bypass_q)
    else $error("bypass stage did not capture zero");

  AST_BSR_CAPTURE: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q == JBS_ST_CAPTURE_DR && sel_bsr) |=> bsr_q == $past(pins_sync))
    else $error("boundary chain did not capture pins");

  AST_UPD_HOLD: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (state_q != JBS_ST_UPDATE_DR && state_q != JBS_ST_RESET) |-> $stable(upd_q))
    else $error("output cells changed outside update");

  AST_PIN_OUT: assert property (@(posedge test_clock_in) disable iff (!resetn)
    (!extest_active) |-> pin_out == core_out)
    else $error("pins not driven by core outside extest");

  COV_EXTEST: cover property (@(posedge test_clock_in) disable iff (!resetn)
    state_q == JBS_ST_UPDATE_DR && ir_q == JBS_IR_EXTEST);
  COV_SAMPLE: cover property (@(posedge test_clock_in) disable iff (!resetn)
    state_q == JBS_ST_CAPTURE_DR && ir_q == JBS_IR_SAMPLE);
  COV_BYPASS: cover property (@(posedge test_clock_in) disable iff (!resetn)
    state_q == JBS_ST_SHIFT_DR && ir_q == JBS_IR_BYPASS);
  COV_RESERVED: cover property (@(posedge test_clock_in) disable iff (!resetn)
    state_q == JBS_ST_SHIFT_DR && !sel_bsr && ir_q != JBS_IR_BYPASS);
  COV_PROC_RESET: cover property (@(posedge test_clock_in) disable iff (!resetn)
    state_q == JBS_ST_SHIFT_DR && !proc_reset_seen);

endmodule

// ===== core/jbs_pkg.sv
/*
  Constants for the boundary scan test logic: TAP states, instruction codes,
  register width and the number of mode-high edges that forces reset.
  Assumes nothing of its surroundings.
*/
package jbs_pkg;

  localparam int unsigned JBS_IR_WIDTH = 3;

  localparam logic [2:0] JBS_IR_EXTEST  = 3'h0;
  localparam logic [2:0] JBS_IR_SAMPLE  = 3'h6;
  localparam logic [2:0] JBS_IR_BYPASS  = 3'h7;
  localparam logic [1:0] JBS_IR_CAPTURE = 2'h1;

  localparam int unsigned JBS_RESET_EDGES = 5;

  typedef enum logic [3:0] {
    JBS_ST_RESET      = 4'h0,
    JBS_ST_IDLE       = 4'h1,
    JBS_ST_SEL_DR     = 4'h2,
    JBS_ST_CAPTURE_DR = 4'h3,
    JBS_ST_SHIFT_DR   = 4'h4,
    JBS_ST_EXIT1_DR   = 4'h5,
    JBS_ST_PAUSE_DR   = 4'h6,
    JBS_ST_EXIT2_DR   = 4'h7,
    JBS_ST_UPDATE_DR  = 4'h8,
    JBS_ST_SEL_IR     = 4'h9,
    JBS_ST_CAPTURE_IR = 4'ha,
    JBS_ST_SHIFT_IR   = 4'hb,
    JBS_ST_EXIT1_IR   = 4'hc,
    JBS_ST_PAUSE_IR   = 4'hd,
    JBS_ST_EXIT2_IR   = 4'he,
    JBS_ST_UPDATE_IR  = 4'hf
  } jbs_state_t;

endpackage

// ===== core/jbs_sync.sv
/*
  Two-flip-flop level synchroniser into the test clock domain.
  Assumes an asynchronous active-low reset tied to the same domain.
*/
`timescale 1ns/10ps
module jbs_sync
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule

// ===== sim/jbs_tester_model.sv
/*
  Boundary-scan tester model: drives test clock, mode select and serial in.
  Assumes the test clock stands still low between frames.
*/
`timescale 1ns/10ps
module jbs_tester_model
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe
);
  logic last_q;

  initial
  begin
    tck    = 1'b0;
    tms    = 1'b1;
    tdi    = 1'b0;
    last_q = 1'b0;
  end

  // released output seen as a toggling level
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #6;
    q = tdo_oe ? tdo : ~last_q;
    last_q = q;
    tck = 1'b1;
    #6;
    tck = 1'b0;
  endtask

  task automatic reset_tap();
    logic b;
    repeat (5) tick(1'b1, 1'b0, b);
    tick(1'b0, 1'b0, b);
  endtask
endmodule

// ===== sim/tb.sv
/*
  Self-checking bench for the boundary scan test logic.
  Assumes the tester model owns the test clock at a 12 ns period.
*/
`timescale 1ns/10ps
module tb
  import jbs_pkg::*;
;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cold_reset_n = 1'b1;
  logic        warm_reset_n = 1'b1;
  logic        supply_good = 1'b1;
  logic [7:0]  pin_in = 8'h00;
  logic [7:0]  core_out = 8'h00;
  logic [7:0]  pin_out;
  logic        ext;
  logic        tck, tms, tdi, tdo, oe;
  logic [31:0] d, q;
  integer      seed = 32'hab936706;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #10 clk = ~clk;

  // processor resets toggle freely
  always @(posedge clk) {cold_reset_n, warm_reset_n, supply_good} <= 3'($random(seed));

  jbs_tap u_jbs_tap (.clk(clk), .resetn(resetn), .test_clock_in(tck), .test_mode_select_in(tms),
    .test_serial_in(tdi), .test_serial_out(tdo), .test_serial_out_oe(oe), .cold_reset_n(cold_reset_n),
    .warm_reset_n(warm_reset_n), .supply_good(supply_good), .pin_in(pin_in), .core_out(core_out),
    .pin_out(pin_out), .extest_active(ext));

  jbs_tester_model u_jbs_tester_model (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(oe));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic tk(input logic m, input logic dd, output logic b);
    u_jbs_tester_model.tick(m, dd, b);
  endtask

  // idle to idle scan, bits out in shift order
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic b;
    dout = '0;
    tk(1'b1, 1'b0, b);
    if (ir)
      tk(1'b1, 1'b0, b);
    tk(1'b0, 1'b0, b);
    tk(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      tk(i == n - 1, din[i], b);
      dout[i] = b;
    end
    tk(1'b1, 1'b0, b);
    tk(1'b0, 1'b0, b);
    // let falling-edge outputs settle
    #2;
  endtask

  function automatic logic [31:0] byp(input logic [31:0] v, input int n);
    return (v << 1) & ((32'h1 << n) - 32'h1);
  endfunction

  function automatic logic bsr(input logic [2:0] c);
    return c == JBS_IR_EXTEST || c == JBS_IR_SAMPLE;
  endfunction

  initial
  begin
    #1000000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    check("oe_por", oe, 0);
    resetn <= 1'b1;
    @(posedge clk);
    u_jbs_tester_model.reset_tap();
    #2;
    check("ext_por", ext, 0);
    d = 32'($random(seed));
    scan(1'b0, 16, d, q);
    check("bypass", q, byp(d, 16));
    for (int c = 0; c < 8; c++)
    begin
      @(posedge clk);
      pin_in <= 8'($random(seed));
      core_out <= 8'($random(seed));
      scan(1'b1, 3, c, q);
      check("ir_cap", q, {1'b0, JBS_IR_CAPTURE});
      check("ext_sel", ext, c == 0);
      d = 32'($random(seed));
      scan(1'b0, 16, d, q);
      check("dr_out", q, bsr(3'(c)) ? {16'h0, core_out, pin_in} : byp(d, 16));
      check("pin_out", pin_out, c == 0 ? d[15:8] : core_out);
      check("oe_idle", oe, 0);
    end
    scan(1'b1, 3, JBS_IR_EXTEST, q);
    check("ext_on", ext, 1);
    u_jbs_tester_model.reset_tap();
    #2;
    check("ext_tlr", ext, 0);
    d = 32'($random(seed));
    scan(1'b0, 8, d, q);
    check("bypass_tlr", q, byp(d, 8));
    scan(1'b1, 3, JBS_IR_EXTEST, q);
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("ext_rst", ext, 0);
    report_and_stop();
  end
endmodule
